// *** pecs_defs.vh ***
/*
  Register offsets, field positions and reset values for the PHY extended
  configuration and status register group. Assumes inclusion by bare name.
*/
`ifndef PECS_DEFS_VH
`define PECS_DEFS_VH

// Register indices; byte address is four times the index
`define PECS_IDX_PEAK_SIGN 12'h1A6
`define PECS_IDX_PKT_LOW 12'h1A8
`define PECS_IDX_PKT_HIGH 12'h1A9
`define PECS_IDX_OP_MODE 12'h1DF
`define PECS_IDX_PIN_MUX 12'h1E0
`define PECS_IDX_ERR_CNT 12'h016
`define PECS_IDX_SFD_CTRL 12'h1E1

`define PECS_RST_OP_MODE 16'h0040
`define PECS_RST_PIN_MUX 16'h417A
`define PECS_RST_ERR_CNT 16'h0001
`define PECS_RST_SFD_CTRL 16'h0000

`define PECS_BIT_BRIDGE 6
`define PECS_BIT_MII_SEL 5
`define PECS_BIT_CNT_MODE 0
`define PECS_BIT_SFD_TX_EN 0
`define PECS_BIT_SFD_RX_EN 1

`define PECS_MODE_RSVD 3'h7
`define PECS_FN_CLK 4'h0
`define PECS_FN_INT 4'h2
`define PECS_FN_LINK 4'h3
`define PECS_FN_TRANSMIT_DELIMITER_PULSE 4'h5
`define PECS_FN_RECEIVE_DELIMITER_PULSE 4'h6
`define PECS_FN_WOL 4'h7
`define PECS_FN_ENERGY 4'h8
`define PECS_FN_ERR 4'h9
`define PECS_FN_LED2 4'hA
`define PECS_FN_LED3 4'hB
`define PECS_FN_CRS 4'hC
`define PECS_FN_COL 4'hD
`define PECS_FN_ZERO 4'hE
`define PECS_FN_ONE 4'hF

`endif

// *** pecs_pin_select.v ***
/*
  Function selector for one general pin: picks one of sixteen sources.
  Assumes all sources are synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pecs_defs.vh"

module pecs_pin_select (
  input wire [3:0] sel,        // Function code
  input wire [15:0] src,       // Candidate sources by code
  input wire energy_ok,        // Copper 1000T/100TX active
  output reg pin               // Selected level
);
  always @* begin
    pin = src[sel];
    if (sel == `PECS_FN_ENERGY) begin
      pin = src[sel] & energy_ok;
    end
    if (sel == `PECS_FN_ZERO) begin
      pin = 1'b0;
    end
    if (sel == `PECS_FN_ONE) begin
      pin = 1'b1;
    end
  end
endmodule // pecs_pin_select
`default_nettype wire

// *** pecs_regs.v ***
/*
  PHY extended configuration and status registers on APB: peak polarity
  flags, test packet counter with snapshot, mode decode, general pin mux.
  Assumes all status inputs are synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pecs_defs.vh"

module pecs_regs #(
  parameter CNT_W = 32                  // Packet counter width
) (
  input wire pclk,                      // APB clock
  input wire presetn,                   // Async reset, active low
  input wire psel,                      // APB select
  input wire penable,                   // APB enable
  input wire pwrite,                    // APB direction
  input wire [15:0] paddr,              // APB byte address
  input wire [31:0] pwdata,             // APB write data
  output reg [31:0] prdata,             // APB read data
  output reg pready,                    // APB ready
  output reg pslverr,                   // APB error
  input wire [4:0] pair_c_peak_polarity, // Pair C signs
  input wire [4:0] pair_d_peak_polarity, // Pair D signs
  input wire checker_packet,            // One pulse per checked packet
  input wire clk_out_src,               // Clock output source
  input wire int_src,                   // Interrupt level
  input wire link_src,                  // Link status
  input wire transmit_delimiter_pulse,  // Transmit SFD pulse
  input wire receive_delimiter_pulse,   // Receive SFD pulse
  input wire wake_on_lan_indication,    // Wake indication
  input wire energy_src,                // Energy detect
  input wire copper_fast_mode,          // 1000T or 100TX operating
  input wire test_error_src,            // Test error indication
  input wire third_indicator_output,    // THIRD_INDICATOR_OUTPUT source
  input wire fourth_indicator_output,   // LED 3 source
  input wire crs_src,                   // Carrier sense
  input wire col_src,                   // Collision
  output reg bridge_direction_select,   // 1: SGMII toward RGMII
  output reg mii_select,                // 1: MII, 0: RGMII
  output reg [2:0] media_operating_mode, // Operating mode code
  output reg gpio0_out,                 // General pin 0
  output reg gpio1_out                  // General pin 1
);
  reg [15:0] op_mode_ff;
  reg [15:0] nxt_op_mode;
  reg [15:0] pin_mux_ff;
  reg [15:0] nxt_pin_mux;
  reg [15:0] err_cnt_ff;
  reg [15:0] nxt_err_cnt;
  reg [15:0] sfd_ctrl_ff;
  reg [15:0] nxt_sfd_ctrl;
  reg [CNT_W-1:0] pkt_cnt_ff;
  reg [CNT_W-1:0] nxt_pkt_cnt;
  reg [CNT_W-1:0] pkt_snap_ff;
  reg [CNT_W-1:0] nxt_pkt_snap;
  reg frozen_ff;
  reg nxt_frozen;
  reg [9:0] sign_ff;
  reg [31:0] rd_word;
  wire acc;
  wire wr;
  wire [11:0] idx;
  wire hit;
  wire sfd_on;
  wire mux0;
  wire mux1;
  wire [15:0] src;

  function is_reg;
    input [11:0] i;
    begin
      is_reg = (i == `PECS_IDX_PEAK_SIGN) || (i == `PECS_IDX_PKT_LOW) ||
               (i == `PECS_IDX_PKT_HIGH) || (i == `PECS_IDX_OP_MODE) ||
               (i == `PECS_IDX_PIN_MUX) || (i == `PECS_IDX_ERR_CNT) ||
               (i == `PECS_IDX_SFD_CTRL);
    end
  endfunction

  assign acc = psel & penable & ~pready;
  assign wr = acc & pwrite;
  assign idx = {2'b00, paddr[11:2]} | {paddr[13:12], 10'h000};
  assign hit = is_reg(idx) & (paddr[1:0] == 2'b00) & (paddr[15:14] == 2'b00);

  // Register write paths; read-only registers have no write path
  always @* begin
    nxt_op_mode = op_mode_ff;
    nxt_pin_mux = pin_mux_ff;
    nxt_err_cnt = err_cnt_ff;
    nxt_sfd_ctrl = sfd_ctrl_ff;
    nxt_frozen = frozen_ff;
    if (wr & hit) begin
      case (idx)
        `PECS_IDX_OP_MODE: begin
          nxt_op_mode = {9'h000, pwdata[6:5], 2'b00, pwdata[2:0]};
        end
        `PECS_IDX_PIN_MUX: begin
          nxt_pin_mux = {8'h00, pwdata[7:0]};
        end
        `PECS_IDX_ERR_CNT: begin
          nxt_err_cnt = {15'h0000, pwdata[`PECS_BIT_CNT_MODE]};
          if (pwdata[1:0] != 2'b00) begin
            nxt_frozen = 1'b1;
          end else begin
            nxt_frozen = 1'b0;
          end
        end
        `PECS_IDX_SFD_CTRL: begin
          nxt_sfd_ctrl = {14'h0000, pwdata[1:0]};
        end
        default: begin
          nxt_op_mode = op_mode_ff;
        end
      endcase
    end
  end

  // Counter saturates in mode zero, otherwise wraps
  always @* begin
    nxt_pkt_cnt = pkt_cnt_ff;
    if (checker_packet) begin
      if (~err_cnt_ff[`PECS_BIT_CNT_MODE] & (&pkt_cnt_ff)) begin
        nxt_pkt_cnt = pkt_cnt_ff;
      end else begin
        nxt_pkt_cnt = pkt_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    nxt_pkt_snap = pkt_snap_ff;
    if (wr & hit & (idx == `PECS_IDX_ERR_CNT) & (pwdata[1:0] != 2'b00)) begin
      nxt_pkt_snap = nxt_pkt_cnt;
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    case (idx)
      `PECS_IDX_PEAK_SIGN: rd_word = {22'h000000, sign_ff};
      `PECS_IDX_PKT_LOW: rd_word = {16'h0000,
        frozen_ff ? pkt_snap_ff[15:0] : pkt_cnt_ff[15:0]};
      `PECS_IDX_PKT_HIGH: rd_word = {16'h0000,
        frozen_ff ? pkt_snap_ff[31:16] : pkt_cnt_ff[31:16]};
      `PECS_IDX_OP_MODE: rd_word = {16'h0000, op_mode_ff};
      `PECS_IDX_PIN_MUX: rd_word = {16'h0000, pin_mux_ff};
      `PECS_IDX_ERR_CNT: rd_word = {16'h0000, err_cnt_ff};
      `PECS_IDX_SFD_CTRL: rd_word = {16'h0000, sfd_ctrl_ff};
      default: rd_word = 32'h00000000;
    endcase
  end

  assign src = {1'b1, 1'b0, col_src, crs_src, fourth_indicator_output,
                third_indicator_output, test_error_src, energy_src,
                wake_on_lan_indication, receive_delimiter_pulse,
                transmit_delimiter_pulse, 1'b0, link_src, int_src, 1'b0,
                clk_out_src};
  assign sfd_on = sfd_ctrl_ff[`PECS_BIT_SFD_TX_EN] |
                  sfd_ctrl_ff[`PECS_BIT_SFD_RX_EN];

  pecs_pin_select u_sel0 (
    .sel(pin_mux_ff[3:0]),
    .src(src),
    .energy_ok(copper_fast_mode),
    .pin(mux0)
  );

  pecs_pin_select u_sel1 (
    .sel(pin_mux_ff[7:4]),
    .src(src),
    .energy_ok(copper_fast_mode),
    .pin(mux1)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode_ff <= `PECS_RST_OP_MODE;
      pin_mux_ff <= `PECS_RST_PIN_MUX & 16'h00FF;
      err_cnt_ff <= `PECS_RST_ERR_CNT;
      sfd_ctrl_ff <= `PECS_RST_SFD_CTRL;
      pkt_cnt_ff <= {CNT_W{1'b0}};
      pkt_snap_ff <= {CNT_W{1'b0}};
      frozen_ff <= 1'b0;
      sign_ff <= 10'h000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bridge_direction_select <= 1'b1;
      mii_select <= 1'b0;
      media_operating_mode <= 3'h0;
      gpio0_out <= 1'b0;
      gpio1_out <= 1'b0;
    end else begin
      op_mode_ff <= nxt_op_mode;
      pin_mux_ff <= nxt_pin_mux;
      err_cnt_ff <= nxt_err_cnt;
      sfd_ctrl_ff <= nxt_sfd_ctrl;
      pkt_cnt_ff <= nxt_pkt_cnt;
      pkt_snap_ff <= nxt_pkt_snap;
      frozen_ff <= nxt_frozen;
      sign_ff <= {pair_d_peak_polarity, pair_c_peak_polarity};
      pready <= acc;
      pslverr <= acc & ~hit;
      if (acc & ~pwrite & hit) begin
        prdata <= rd_word;
      end else if (acc) begin
        prdata <= 32'h00000000;
      end
      bridge_direction_select <= op_mode_ff[`PECS_BIT_BRIDGE];
      mii_select <= op_mode_ff[`PECS_BIT_MII_SEL];
      media_operating_mode <= op_mode_ff[2:0];
      gpio0_out <= sfd_on ? receive_delimiter_pulse : mux0;
      gpio1_out <= sfd_on ? transmit_delimiter_pulse : mux1;
    end
  end
endmodule // pecs_regs
`default_nettype wire

// *** pecs_regs_checker.sv ***
/* Checker of APB timing, error replies and mode outputs of pecs_regs.
   Assumes binding to pecs_regs; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module pecs_regs_checker (
  input wire pclk, // Clock
  input wire presetn, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Direction
  input wire [15:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire bridge_direction_select, // Bridge
  input wire mii_select, // MII
  input wire [2:0] media_operating_mode // Mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  property p_answer;
    s_take |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err_data;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error data");
  property p_unmapped;
    (s_take and (paddr == 16'h0004)) |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_ro_write;
    (s_take and (pwrite && paddr == 16'h0698)) |=> !pslverr;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro error");
  property p_peak_rsv;
    (s_take and (!pwrite && paddr == 16'h0698)) |=> prdata[31:10] == 22'h0;
  endproperty
  a_peak_rsv: assert property (p_peak_rsv) else $error("peak rsv");
  property p_mode_rsv;
    (s_take and (!pwrite && paddr == 16'h077C)) |=>
      prdata[31:7] == 25'h0 && prdata[4:3] == 2'h0;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("mode rsv");
  property p_mode_out;
    (s_take and (pwrite && paddr == 16'h077C)) |-> ##2
      bridge_direction_select == $past(pwdata[6], 2) &&
      mii_select == $past(pwdata[5], 2) &&
      media_operating_mode == $past(pwdata[2:0], 2);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode out");
endmodule // pecs_regs_checker
`default_nettype wire

// *** test_phy_ext_config_status_regs.sv ***
/* Self-checking bench of pecs_regs over APB.
   Assumes pecs_defs.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "pecs_defs.vh"
module test_phy_ext_config_status_regs;
  localparam [15:0] A_PK = {`PECS_IDX_PEAK_SIGN, 2'b00};
  localparam [15:0] A_LO = {`PECS_IDX_PKT_LOW, 2'b00};
  localparam [15:0] A_HI = {`PECS_IDX_PKT_HIGH, 2'b00};
  localparam [15:0] A_MD = {`PECS_IDX_OP_MODE, 2'b00};
  localparam [15:0] A_MX = {`PECS_IDX_PIN_MUX, 2'b00};
  localparam [15:0] A_EC = {`PECS_IDX_ERR_CNT, 2'b00};
  localparam [15:0] A_SF = {`PECS_IDX_SFD_CTRL, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pkt, cf;
  logic [15:0] paddr, src;
  logic [31:0] pwdata, prdata, rdata;
  logic [4:0] pc, pd;
  logic g0, g1, bds, mii, rerr, e;
  logic [2:0] mom;
  int error_cnt, compares, c, k;
  pecs_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pair_c_peak_polarity(pc), .pair_d_peak_polarity(pd),
    .checker_packet(pkt), .clk_out_src(src[0]), .int_src(src[2]),
    .link_src(src[3]), .transmit_delimiter_pulse(src[5]),
    .receive_delimiter_pulse(src[6]), .wake_on_lan_indication(src[7]),
    .energy_src(src[8]), .copper_fast_mode(cf), .test_error_src(src[9]),
    .third_indicator_output(src[10]), .fourth_indicator_output(src[11]),
    .crs_src(src[12]), .col_src(src[13]), .bridge_direction_select(bds),
    .mii_select(mii), .media_operating_mode(mom), .gpio0_out(g0),
    .gpio1_out(g1));
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [15:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk("rdata", ex, rdata);
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task pulses(input int n);
    @(posedge pclk);
    pkt <= 1'b1;
    repeat (n) @(posedge pclk);
    pkt <= 1'b0;
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, pkt, cf} = 6'h0;
    {paddr, src, pwdata, pc, pd} = 74'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_MD, 32'h00000040);
    rdchk(A_MX, 32'h0000007A);
    rdchk(A_LO, 32'h00000000);
    pc <= 5'h15;
    pd <= 5'h0A;
    apb(1'b1, A_PK, 32'hFFFFFFFF);
    rdchk(A_PK, 32'h00000155);
    apb(1'b1, 16'h0004, 32'h1);
    chk("err", 32'h1, {31'h0, rerr});
    apb(1'b1, A_MD, 32'h0000FFA7);
    rdchk(A_MD, 32'h00000027);
    settle;
    chk("mode", 32'h0F, {27'h0, bds, mii, mom});
    apb(1'b1, A_MD, 32'h00000040);
    settle;
    chk("mode", 32'h10, {27'h0, bds, mii, mom});
    pulses(5);
    apb(1'b1, A_EC, 32'h2);
    pulses(3);
    apb(1'b1, A_LO, 32'hFFFF);
    rdchk(A_LO, 32'h00000005);
    rdchk(A_HI, 32'h00000000);
    apb(1'b1, A_EC, 32'h0);
    rdchk(A_LO, 32'h00000008);
    pulses(2);
    apb(1'b1, A_EC, 32'h1);
    pulses(1);
    rdchk(A_LO, 32'h0000000A);
    cf <= 1'b1;
    for (c = 0; c < 16; c++) begin
      apb(1'b1, A_MX, {24'h0, c[3:0], c[3:0]});
      for (k = 0; k < 2; k++) begin
        @(posedge pclk);
        src <= k ? ~(16'h1 << c) : (16'h1 << c);
        settle;
        e = (c == 15) || (k == 0 && c != 1 && c != 4 && c != 14);
        chk("pins", {30'h0, e, e}, {30'h0, g1, g0});
      end
    end
    apb(1'b1, A_MX, 32'h88);
    @(posedge pclk);
    src <= 16'h0100;
    cf <= 1'b0;
    settle;
    chk("energy", 32'h0, {30'h0, g1, g0});
    apb(1'b1, A_MX, 32'hFF);
    for (c = 1; c < 3; c++) begin
      apb(1'b1, A_SF, c);
      @(posedge pclk);
      src <= 16'h0020;
      settle;
      chk("sfd", 32'h2, {30'h0, g1, g0});
      @(posedge pclk);
      src <= 16'h0040;
      settle;
      chk("sfd", 32'h1, {30'h0, g1, g0});
    end
    wrap_up;
  end
endmodule // test_phy_ext_config_status_regs
bind pecs_regs pecs_regs_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bridge_direction_select(bridge_direction_select),
  .mii_select(mii_select), .media_operating_mode(media_operating_mode));
`default_nettype wire
